// ---- src/cspc_config_bank.sv ----
// Purpose: power and conversion control register, banked register space, conversion sequencer
// Assumes: serial framing is done outside; this block sees address-load, write and read strobes
// Notes: result reads return zero until configuration loaded and one sequence has finished
// Function
// - Register space split into control, per-stage configuration and per-stage result banks.
// - Result bank updates automatically each conversion and stays host readable.
// - Configuration and results undefined until configuration bank has been written.
// - Mode field: 00 full power every 36 ms, 10 low power, others shutdown.
// - Low power wake interval 200, 400, 600 or 800 ms by code.
// - Stages per sequence equals field plus one, at most twelve.
// - Decimation 256, 128, or 64 for codes 10 and 11.
// - Soft reset bit restores all register defaults and clears itself.
// - Excitation bit zero drives sensor inputs, one disconnects them.
// - Bias field selects nominal, +20%, +35% or +50% converter bias.
// - Address pointer advances after each register written, no wrap at top.
`timescale 1ns/1ps
module cspc_config_bank #(
	parameter int MS_CYCLES = cspc_pkg::MS_CYCLES,
	parameter int STAGES = cspc_pkg::MAX_STAGES
) (
	input wire logic clk_sys, // system clock, 10 MHz
	input wire logic rst_n, // synchronous reset, active low
	input wire logic reg_addr_load, // load register pointer
	input wire logic [9:0] reg_addr, // pointer value to load
	input wire logic reg_wr, // write one 16-bit word at pointer
	input wire logic [15:0] reg_wdata, // write data
	input wire logic reg_rd, // read one word at pointer
	output logic [15:0] reg_rdata, // read data
	output logic reg_rvalid, // read data valid pulse
	output logic [9:0] reg_ptr, // current register pointer
	output logic conv_start, // start one stage conversion
	output cspc_pkg::cspc_conv_type conv_req, // settings of that conversion
	input wire logic conv_done, // stage conversion finished
	input wire logic [15:0] conv_result, // stage result
	output logic seq_done, // sequence completed pulse
	output logic excitation_en, // excitation source to sensor inputs
	output logic [1:0] converter_bias_trim, // bias current select
	output logic powered, // active mode is not shutdown
	output logic cfg_loaded, // configuration bank written
	output logic results_valid // result bank holds valid data
);
	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [15:0] bank1_q [0:cspc_pkg::BANK1_WORDS-1];
	logic [15:0] cfg_q [0:cspc_pkg::CFG_WORDS-1];
	logic [15:0] res_q [0:STAGES-1];
	logic [9:0] ptr_q;
	logic ptr_end_q;
	cspc_pkg::cspc_state_type state_q;
	logic [1:0] act_mode_q;
	logic [3:0] act_last_q;
	logic [8:0] act_decim_q;
	logic [3:0] stage_q;
	logic ms_tick;
	logic fire;

	function automatic logic [8:0] decim_of(input logic [1:0] code);
		decim_of = (code == 2'b00) ? 9'h100 : (code == 2'b01) ? 9'h080 : 9'h040;
	endfunction

	function automatic logic mode_on(input logic [1:0] mode);
		mode_on = (mode == cspc_pkg::MODE_FULL) || (mode == cspc_pkg::MODE_LOW);
	endfunction

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire logic [15:0] ctrl = bank1_q[0];
	wire logic [1:0] f_mode = ctrl[cspc_pkg::F_MODE_LO +: 2];
	wire logic [1:0] f_delay = ctrl[cspc_pkg::F_DELAY_LO +: 2];
	wire logic [3:0] f_stages = ctrl[cspc_pkg::F_STAGES_LO +: 4];
	wire logic [1:0] f_decim = ctrl[cspc_pkg::F_DECIM_LO +: 2];
	wire logic wr_ok = reg_wr && !reg_addr_load && !ptr_end_q;
	wire logic in_bank1 = (ptr_q <= cspc_pkg::BANK1_LAST);
	wire logic in_cfg = (ptr_q >= cspc_pkg::CFG_FIRST) && (ptr_q <= cspc_pkg::CFG_LAST);
	wire logic in_res = (ptr_q >= cspc_pkg::RES_FIRST) && (ptr_q < cspc_pkg::RES_FIRST + 10'(STAGES));
	wire logic [2:0] b1_idx = ptr_q[2:0];
	wire logic [6:0] cfg_idx = 7'(ptr_q - cspc_pkg::CFG_FIRST);
	wire logic [3:0] res_idx = 4'(ptr_q - cspc_pkg::RES_FIRST);
	wire logic soft_rst = wr_ok && (ptr_q == cspc_pkg::ADDR_CTRL) && reg_wdata[cspc_pkg::F_SOFT_RESET];
	wire logic clear = !rst_n || soft_rst;
	wire logic [3:0] stages_clamp = (f_stages > cspc_pkg::STAGE_CODE_MAX) ? cspc_pkg::STAGE_CODE_MAX : f_stages;
	wire logic [9:0] interval_ms = (f_mode == cspc_pkg::MODE_LOW) ?
		10'(cspc_pkg::LOW_POWER_STEP_MS * (10'(f_delay) + 10'd1)) : cspc_pkg::FULL_POWER_INTERVAL_MS;
	// a fire that lands mid-sequence is dropped, not queued
	wire logic start_seq = fire && (state_q == cspc_pkg::ST_IDLE) && cfg_loaded;
	wire logic stage_fin = (state_q == cspc_pkg::ST_WAIT) && conv_done;
	wire logic last_fin = stage_fin && (stage_q == act_last_q);
	wire logic [15:0] rd_word = in_bank1 ? bank1_q[b1_idx] :
		in_cfg ? cfg_q[cfg_idx] :
		(in_res && results_valid) ? res_q[res_idx] : 16'h0000;

	// ----------------------------------------------------------------
	// timebase
	// ----------------------------------------------------------------
	cspc_ms_tick #(
		.CYCLES(MS_CYCLES)
	) u_tick (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick(ms_tick)
	);

	// full and low power share the count; only shutdown restarts the interval
	cspc_wake_timer u_wake (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.run(mode_on(f_mode)),
		.tick(ms_tick),
		.interval_ms(interval_ms),
		.fire(fire)
	);

	// ----------------------------------------------------------------
	// register port
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n || reg_addr_load) begin
			ptr_q <= rst_n ? reg_addr : cspc_pkg::ADDR_CTRL;
			ptr_end_q <= 1'b0;
		end else if (reg_wr || reg_rd) begin
			if (ptr_q == cspc_pkg::ADDR_MAX) begin
				ptr_end_q <= reg_wr;
			end else begin
				ptr_q <= ptr_q + 10'd1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (clear) begin
			for (int i = 0; i < cspc_pkg::BANK1_WORDS; i++) begin
				bank1_q[i] <= (i == 2) ? cspc_pkg::AMB0_RESET : cspc_pkg::BANK1_RESET;
			end
		end else if (wr_ok && in_bank1) begin
			bank1_q[b1_idx] <= (b1_idx == 3'd0) ? (reg_wdata & cspc_pkg::CTRL_WR_MASK) : reg_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (wr_ok && in_cfg) begin
			cfg_q[cfg_idx] <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (clear) begin
			cfg_loaded <= 1'b0;
		end else if (wr_ok && ptr_q == cspc_pkg::CFG_LAST) begin
			cfg_loaded <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd && !reg_addr_load;
			if (reg_rd && !reg_addr_load) begin
				reg_rdata <= rd_word;
			end
		end
	end

	// ----------------------------------------------------------------
	// conversion sequencer
	// ----------------------------------------------------------------
	// stage count and decimation latched only when idle; bias and excitation are taken live from ctrl at each stage issue
	always_ff @(posedge clk_sys) begin
		if (clear) begin
			state_q <= cspc_pkg::ST_IDLE;
			act_mode_q <= cspc_pkg::MODE_FULL;
			act_last_q <= 4'h0;
			act_decim_q <= 9'h100;
			stage_q <= 4'h0;
		end else begin
			case (state_q)
				cspc_pkg::ST_IDLE: begin
					act_mode_q <= f_mode;
					if (start_seq && mode_on(f_mode)) begin
						act_last_q <= stages_clamp;
						act_decim_q <= decim_of(f_decim);
						stage_q <= 4'h0;
						state_q <= cspc_pkg::ST_ISSUE;
					end
				end
				cspc_pkg::ST_ISSUE: begin
					state_q <= cspc_pkg::ST_WAIT;
				end
				cspc_pkg::ST_WAIT: begin
					if (last_fin) begin
						state_q <= cspc_pkg::ST_IDLE;
					end else if (stage_fin) begin
						stage_q <= stage_q + 4'h1;
						state_q <= cspc_pkg::ST_ISSUE;
					end
				end
				default: begin
					state_q <= cspc_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (stage_fin && stage_q < 4'(STAGES)) begin
			res_q[stage_q] <= conv_result;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (clear) begin
			conv_start <= 1'b0;
			conv_req <= '0;
			seq_done <= 1'b0;
			results_valid <= 1'b0;
		end else begin
			conv_start <= (state_q == cspc_pkg::ST_ISSUE);
			seq_done <= last_fin;
			if (last_fin) begin
				results_valid <= 1'b1;
			end
			if (state_q == cspc_pkg::ST_ISSUE) begin
				conv_req.stage <= stage_q;
				conv_req.decim <= act_decim_q;
				conv_req.bias <= ctrl[cspc_pkg::F_BIAS_LO +: 2];
				conv_req.excite_off <= ctrl[cspc_pkg::F_EXCITE_OFF];
			end
		end
	end

	assign excitation_en = !ctrl[cspc_pkg::F_EXCITE_OFF];
	assign converter_bias_trim = ctrl[cspc_pkg::F_BIAS_LO +: 2];
	assign powered = mode_on(act_mode_q) || (state_q != cspc_pkg::ST_IDLE);
	assign reg_ptr = ptr_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_soft_reset_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
		soft_rst |=> (bank1_q[0] == cspc_pkg::CTRL_RESET) && !cfg_loaded)
		else $error("soft reset did not restore control defaults");
	a_soft_bit_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!ctrl[cspc_pkg::F_SOFT_RESET])
		else $error("soft reset bit read back as one");
	a_ptr_advance: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(reg_wr && !reg_addr_load && ptr_q != cspc_pkg::ADDR_MAX) |=> ptr_q == $past(ptr_q) + 10'd1)
		else $error("pointer did not advance after a write");
	a_ptr_no_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(reg_wr && !reg_addr_load && ptr_q == cspc_pkg::ADDR_MAX) |=> ptr_q == cspc_pkg::ADDR_MAX && ptr_end_q)
		else $error("pointer wrapped past the top address");
	a_no_conv_shutdown: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(state_q == cspc_pkg::ST_ISSUE) && stage_q == 4'h0 |-> mode_on(act_mode_q) && cfg_loaded)
		else $error("sequence started in shutdown or before configuration");
	a_stage_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
		conv_start |-> conv_req.stage <= act_last_q && act_last_q <= cspc_pkg::STAGE_CODE_MAX)
		else $error("stage index beyond programmed count");
	a_settings_hold: assert property (@(posedge clk_sys) disable iff (!rst_n || soft_rst)
		(state_q != cspc_pkg::ST_IDLE) ##1 (state_q != cspc_pkg::ST_IDLE) |-> $stable(act_decim_q) && $stable(act_last_q))
		else $error("sequence settings changed mid-sequence");
	a_result_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
		stage_fin |=> res_q[$past(stage_q)] == $past(conv_result))
		else $error("result bank not updated on conversion end");
	a_decim_map: assert property (@(posedge clk_sys) disable iff (!rst_n)
		start_seq && mode_on(f_mode) && f_decim[1] |=> ##1 conv_req.decim == 9'h040 && conv_start)
		else $error("decimation code not mapped to 64");
	a_excite_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
		excitation_en != ctrl[cspc_pkg::F_EXCITE_OFF])
		else $error("excitation output disagrees with control bit");
	a_ptr_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_addr_load |=> ptr_q == $past(reg_addr))
		else $error("pointer not loaded from address input");
	a_rvalid_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && !reg_addr_load |=> reg_rvalid)
		else $error("read strobe gave no valid pulse");
	a_result_early: assert property (@(posedge clk_sys) disable iff (!rst_n)
		reg_rd && !reg_addr_load && in_res && !results_valid |=> reg_rdata == 16'h0000)
		else $error("result bank readable before valid");
	a_cfg_loaded: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_ok && ptr_q == cspc_pkg::CFG_LAST |=> cfg_loaded)
		else $error("configuration load end not flagged");
	a_done_valid: assert property (@(posedge clk_sys) disable iff (!rst_n || soft_rst)
		last_fin |=> seq_done && results_valid)
		else $error("sequence end did not mark results valid");
	a_idle_when_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
		state_q == cspc_pkg::ST_IDLE && !mode_on(f_mode) |=> state_q == cspc_pkg::ST_IDLE)
		else $error("sequence left idle in shutdown");
	a_req_bias: assert property (@(posedge clk_sys) disable iff (!rst_n)
		conv_start |-> conv_req.bias == $past(converter_bias_trim))
		else $error("conversion bias differs from control field");
	a_req_excite: assert property (@(posedge clk_sys) disable iff (!rst_n)
		conv_start |-> conv_req.excite_off == !$past(excitation_en))
		else $error("conversion excitation differs from control bit");
endmodule

// ---- src/cspc_pkg.sv ----
// Purpose: shared constants and types of the sensor power and conversion control bank
// Assumes: 10 MHz system clock, 16-bit registers, 10-bit register address
// Notes: all offsets, fields, defaults and timing figures live here
package cspc_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [9:0] FULL_POWER_INTERVAL_MS = 10'd36;
	localparam logic [9:0] LOW_POWER_STEP_MS = 10'd200;

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 10;
	localparam int DATA_W = 16;
	localparam logic [9:0] ADDR_CTRL = 10'h000;
	localparam logic [9:0] ADDR_CAL_EN = 10'h001;
	localparam logic [9:0] ADDR_AMB0 = 10'h002;
	localparam logic [9:0] BANK1_LAST = 10'h007;
	localparam logic [9:0] CFG_FIRST = 10'h080;
	localparam logic [9:0] CFG_LAST = 10'h0df;
	localparam logic [9:0] RES_FIRST = 10'h0e0;
	localparam logic [9:0] ADDR_MAX = 10'h3ff;
	localparam int BANK1_WORDS = 8;
	localparam int CFG_WORDS = 96;
	localparam int MAX_STAGES = 12;

	// ----------------------------------------------------------------
	// control register fields
	// ----------------------------------------------------------------
	localparam int F_MODE_LO = 0;
	localparam int F_DELAY_LO = 2;
	localparam int F_STAGES_LO = 4;
	localparam int F_DECIM_LO = 8;
	localparam int F_SOFT_RESET = 10;
	localparam int F_EXCITE_OFF = 12;
	localparam int F_BIAS_LO = 14;
	localparam logic [15:0] CTRL_WR_MASK = 16'hdbff;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] BANK1_RESET = 16'h0000;
	localparam logic [15:0] AMB0_RESET = 16'h0ff0;
	localparam logic [3:0] STAGE_CODE_MAX = 4'hb;

	typedef enum logic [1:0] {
		MODE_FULL = 2'b00,
		MODE_OFF_A = 2'b01,
		MODE_LOW = 2'b10,
		MODE_OFF_B = 2'b11
	} cspc_mode_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ISSUE = 2'b01,
		ST_WAIT = 2'b10
	} cspc_state_type;

	// one conversion request towards the converter front end
	typedef struct packed {
		logic [3:0] stage;
		logic [8:0] decim;
		logic [1:0] bias;
		logic excite_off;
	} cspc_conv_type;

endpackage

// ---- src/cspc_ms_tick.sv ----
// Purpose: one-cycle enable every millisecond
// Assumes: single system clock
// Notes: period is a parameter so simulation can shorten it
`timescale 1ns/1ps
module cspc_ms_tick #(
	parameter int CYCLES = 10000
) (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // synchronous reset, active low
	output logic tick // one-cycle millisecond enable
);
	logic [31:0] cnt_q;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			cnt_q <= 32'h0000_0000;
			tick <= 1'b0;
		end else begin
			tick <= (cnt_q == 32'(CYCLES - 1));
			cnt_q <= (cnt_q == 32'(CYCLES - 1)) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
		end
	end
endmodule

// ---- src/cspc_wake_timer.sv ----
// Purpose: counts millisecond enables and fires once per conversion interval
// Assumes: tick is a one-cycle enable
// Notes: holds at zero while not running, so leaving shutdown restarts the interval
`timescale 1ns/1ps
module cspc_wake_timer (
	input wire logic clk_sys, // system clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic run, // count while high
	input wire logic tick, // millisecond enable
	input wire logic [9:0] interval_ms, // interval length in ms
	output logic fire // one-cycle pulse at interval end
);
	logic [9:0] ms_q;
	wire logic at_end = (ms_q + 10'd1 >= interval_ms);

	always_ff @(posedge clk_sys) begin
		if (!rst_n || !run) begin
			ms_q <= 10'h000;
			fire <= 1'b0;
		end else begin
			fire <= tick && at_end;
			if (tick) begin
				ms_q <= at_end ? 10'h000 : ms_q + 10'd1;
			end
		end
	end
endmodule

// ---- verification/cspc_conv_model.sv ----
// Purpose: behavioural converter front end answering stage conversion requests
// Assumes: one conv_start pulse per stage, settings valid with it
// Notes: delay is an input so the bench can answer promptly or slowly
`timescale 1ns/1ps
module cspc_conv_model (
	input wire logic clk_sys, // system clock
	input wire logic conv_start, // stage start pulse
	input cspc_pkg::cspc_conv_type conv_req, // stage settings
	input wire logic [7:0] delay, // cycles from start to done, at least 1
	output logic conv_done = 1'b0, // stage done pulse
	output logic [15:0] conv_result = 16'h0000 // stage result, valid with done
);
	int cnt = 0;
	logic [3:0] stg = 4'h0;

	// result line toggles outside done so a stale value is never mistaken for data
	always @(posedge clk_sys) begin
		conv_done <= 1'b0;
		conv_result <= ~conv_result;
		if (conv_start) begin
			cnt <= delay;
			stg <= conv_req.stage;
		end else if (cnt == 1) begin
			conv_done <= 1'b1;
			conv_result <= {12'h5a0, stg};
			cnt <= 0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end
	end
endmodule

// ---- verification/cspc_config_bank_test.sv ----
// Purpose: self-checking bench of the power and conversion control bank
// Assumes: MS_CYCLES shortened to 10, so one ms is ten clocks
// Notes: the bench acts as host; the converter is a behavioural model
`timescale 1ns/1ps
`define CHK(nm, g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module cspc_config_bank_test;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic reg_addr_load = 1'b0;
	logic [9:0] reg_addr = 10'h000;
	logic reg_wr = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata, conv_result;
	logic [9:0] reg_ptr;
	logic [1:0] converter_bias_trim;
	logic reg_rvalid, conv_start, conv_done, seq_done, excitation_en, powered, cfg_loaded, results_valid;
	cspc_pkg::cspc_conv_type conv_req;
	logic [7:0] dly = 8'h14;
	int num_errors = 0;
	int checked = 0;
	int cyc = 0;
	int t0 = 0;

	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) cyc <= cyc + 1;

	cspc_config_bank #(.MS_CYCLES(10), .STAGES(12)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.reg_addr_load(reg_addr_load), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_ptr(reg_ptr),
		.conv_start(conv_start), .conv_req(conv_req), .conv_done(conv_done), .conv_result(conv_result),
		.seq_done(seq_done), .excitation_en(excitation_en), .converter_bias_trim(converter_bias_trim),
		.powered(powered), .cfg_loaded(cfg_loaded), .results_valid(results_valid));
	cspc_conv_model u_conv (.clk_sys(clk_sys), .conv_start(conv_start), .conv_req(conv_req), .delay(dly),
		.conv_done(conv_done), .conv_result(conv_result));

	// ----------------------------------------------------------------
	// host register access
	// ----------------------------------------------------------------
	task automatic ld(input logic [9:0] a);
		@(negedge clk_sys);
		reg_addr_load = 1'b1;
		reg_addr = a;
		@(negedge clk_sys);
		reg_addr_load = 1'b0;
	endtask
	task automatic wr(input logic [15:0] d);
		@(negedge clk_sys);
		reg_wr = 1'b1;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask
	task automatic rdn(input logic [15:0] e, input string nm);
		int w;
		w = 0;
		@(negedge clk_sys);
		reg_rd = 1'b1;
		@(negedge clk_sys);
		reg_rd = 1'b0;
		while (reg_rvalid !== 1'b1 && w < 3) begin
			@(negedge clk_sys);
			w++;
		end
		`CHK("rvalid", reg_rvalid, 1'b1)
		`CHK(nm, reg_rdata, e)
	endtask
	// stop first, so the wake timer restarts from the new setting
	task automatic set_ctrl(input logic [15:0] v);
		ld(cspc_pkg::ADDR_CTRL);
		wr(16'h0001);
		ld(cspc_pkg::ADDR_CTRL);
		wr(v);
		t0 = cyc;
	endtask
	task automatic no_starts(input int n);
		int s;
		s = 0;
		repeat (n) begin
			@(negedge clk_sys);
			if (conv_start === 1'b1) s++;
		end
		`CHK("stray starts", s, 0)
	endtask
	// a seq_done before the first start is left over and ignored
	task automatic run_seq(input int n, input int dec, input logic [1:0] b, input logic ex, input int iv);
		int i;
		int w;
		i = 0;
		w = 0;
		while (!(i > 0 && seq_done === 1'b1) && w < iv + 600) begin
			@(negedge clk_sys);
			w++;
			if (conv_start === 1'b1) begin
				if (i == 0) `CHK("interval", (cyc - t0 >= iv - 10 && cyc - t0 <= iv + 5), 1'b1)
				`CHK("stage", conv_req.stage, i[3:0])
				`CHK("decim", conv_req.decim, dec[8:0])
				`CHK("bias", conv_req.bias, b)
				`CHK("excite", conv_req.excite_off, ex)
				i++;
			end
		end
		`CHK("stage count", i, n)
		`CHK("results valid", results_valid, 1'b1)
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		`CHK("excite pin", excitation_en, 1'b1)
		`CHK("powered", powered, 1'b1)
		`CHK("cfg loaded", cfg_loaded, 1'b0)
		ld(cspc_pkg::ADDR_CTRL);
		rdn(16'h0000, "ctrl reset");
		rdn(16'h0000, "cal reset");
		rdn(16'h0ff0, "amb0 reset");
		ld(cspc_pkg::RES_FIRST);
		rdn(16'h0000, "result early");
		no_starts(400);
	endtask
	task automatic t_init();
		logic [15:0] bank1 [8];
		bank1 = '{16'h82b2, 16'h0000, 16'h3230, 16'h0419, 16'h0340, 16'h0000, 16'h0000, 16'h0000};
		ld(cspc_pkg::CFG_FIRST);
		for (int i = 0; i < 96; i++) wr(16'h1000 + 16'(i));
		`CHK("ptr", reg_ptr, 10'h0e0)
		`CHK("cfg loaded", cfg_loaded, 1'b1)
		ld(cspc_pkg::ADDR_CTRL);
		for (int i = 0; i < 8; i++) wr(bank1[i]);
		ld(cspc_pkg::ADDR_CAL_EN);
		wr(16'h0fff);
		ld(cspc_pkg::ADDR_CTRL);
		for (int i = 0; i < 4; i++) rdn(i == 1 ? 16'h0fff : bank1[i], "bank1");
		ld(10'h008);
		rdn(16'h0000, "int status");
		`CHK("bias pin", converter_bias_trim, 2'b10)
		// full and low power share one count, so restart it through shutdown to time the interval
		set_ctrl(bank1[0]);
		run_seq(12, 64, 2'b10, 1'b0, 2000);
		dly = 8'h01;
		ld(cspc_pkg::RES_FIRST);
		for (int i = 0; i < 12; i++) rdn({12'h5a0, 4'(i)}, "result");
	endtask
	task automatic t_modes();
		logic [15:0] mv [4];
		int mn [4];
		int md [4];
		mv = '{16'h0100, 16'h1230, 16'h03f0, 16'hc000};
		mn = '{1, 4, 12, 1};
		md = '{128, 64, 64, 256};
		for (int k = 0; k < 4; k++) begin
			set_ctrl(mv[k]);
			`CHK("excite pin", excitation_en, ~mv[k][12])
			`CHK("bias pin", converter_bias_trim, mv[k][15:14])
			run_seq(mn[k], md[k], mv[k][15:14], mv[k][12], 360);
		end
	endtask
	task automatic t_low_power();
		for (int c = 1; c < 4; c++) begin
			set_ctrl({12'h000, 2'(c), 2'b10});
			run_seq(1, 256, 2'b00, 1'b0, 2000 * (c + 1));
		end
	endtask
	task automatic t_shutdown();
		set_ctrl(16'h0001);
		`CHK("powered", powered, 1'b0)
		no_starts(500);
		set_ctrl(16'h0003);
		`CHK("powered", powered, 1'b0)
		no_starts(500);
	endtask
	task automatic t_soft_reset();
		set_ctrl(16'h0000);
		run_seq(1, 256, 2'b00, 1'b0, 360);
		ld(cspc_pkg::ADDR_CTRL);
		wr(16'h86b2);
		ld(cspc_pkg::ADDR_CTRL);
		rdn(16'h0000, "ctrl after soft");
		rdn(16'h0000, "cal after soft");
		rdn(16'h0ff0, "amb0 after soft");
		`CHK("cfg after soft", cfg_loaded, 1'b0)
		`CHK("valid after soft", results_valid, 1'b0)
		ld(cspc_pkg::RES_FIRST);
		rdn(16'h0000, "result after soft");
	endtask
	task automatic t_top();
		ld(cspc_pkg::ADDR_MAX);
		wr(16'h1234);
		wr(16'h5678);
		`CHK("ptr at top", reg_ptr, 10'h3ff)
	endtask

	// ----------------------------------------------------------------
	// run control
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk_sys);
		num_errors++;
		test_done();
	end
	initial begin
		repeat (6) @(negedge clk_sys);
		rst_n = 1'b1;
		t_reset();
		t_init();
		t_modes();
		t_low_power();
		t_shutdown();
		t_soft_reset();
		t_top();
		test_done();
	end
endmodule
